//--- pelw_assertions.sv
`timescale 1ns/10ps
`include "pelw_cfg.svh"
module pelw_chk
#(
  parameter int ADDR_W = 18
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [11:0] parity_fault,
  input wire logic software_panic,
  input wire logic loop_overrun,
  input wire logic stack_overrun,
  input wire logic frame_start,
  input wire logic panic_flag
);
  logic wd_seen_q;
  wire logic [15:0] idx = paddr[ADDR_W-1:2];
  wire logic rd_acc = psel && penable && !pwrite;
  wire logic clr_wr = psel && penable && pwrite &&
    idx == `PELW_IDX_CLEAR && pwdata[0];
  wire logic any_flt = (|parity_fault) || software_panic ||
    loop_overrun || stack_overrun;

  // Watchdog faults are only possible once a frame has armed it
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      wd_seen_q <= 1'h0;
    else if (frame_start)
      wd_seen_q <= 1'h1;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_upper; prdata[31:16] == 16'h0; endproperty
  a_upper: assert property (p_upper) else $error("prdata upper set");
  property p_err_phase; pslverr |-> psel && penable; endproperty
  a_err_phase: assert property (p_err_phase) else $error("stray pslverr");
  property p_unmapped; psel && penable && idx == 16'hF429 |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no pslverr");
  property p_flag_hold;
    $fell(panic_flag) |-> $past(clr_wr, 1) || $past(clr_wr, 2) ||
      $past(clr_wr, 3);
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag fell without clear");
  property p_flag_cause; $rose(panic_flag) |-> $past(any_flt) || wd_seen_q;
  endproperty
  a_flag_cause: assert property (p_flag_cause)
    else $error("flag rose without fault");
  property p_flag_rd;
    rd_acc && idx == `PELW_IDX_FLAG && $stable(panic_flag) |->
      prdata == {31'h0, panic_flag} && !pslverr;
  endproperty
  a_flag_rd: assert property (p_flag_rd)
    else $error("flag read mismatch");
  property p_reload_w; rd_acc && idx == `PELW_IDX_WD_RELOAD |->
    prdata[31:13] == 19'h0; endproperty
  a_reload_w: assert property (p_reload_w)
    else $error("reload reserved bits set");
endmodule : pelw_chk

//--- pelw_capture.sv
`timescale 1ns/10ps
`include "pelw_cfg.svh"
module pelw_capture
  import pelw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire pelw_code_t raw_fault,
  input wire pelw_code_t fault_mask,
  input wire logic clear,
  output logic flag,
  output pelw_code_t code,
  output logic new_error
);

  pelw_code_t unmasked;
  logic any_fault;
  logic flag_q;
  pelw_code_t code_q;

  assign unmasked = raw_fault & ~fault_mask;
  assign any_fault = |unmasked;
  assign new_error = any_fault & (~flag_q | clear);
  assign flag = flag_q;
  assign code = code_q;

  // A fault in the clear cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_q <= 1'b0;
    else if (clear)
      flag_q <= any_fault;
    else if (any_fault)
      flag_q <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      code_q <= '0;
    else if (clear)
      code_q <= unmasked;
    else if (!flag_q && any_fault)
      code_q <= unmasked;
  end

endmodule : pelw_capture

//--- pelw_cfg.svh
`ifndef PELW_CFG_SVH
`define PELW_CFG_SVH

// Register indices; byte address is four times the index
`define PELW_IDX_CLEAR 16'hF421
`define PELW_IDX_PARITY_MASK 16'hF422
`define PELW_IDX_SOFT_MASK 16'hF423
`define PELW_IDX_WD_MASK 16'hF424
`define PELW_IDX_STACK_MASK 16'hF425
`define PELW_IDX_LOOP_MASK 16'hF426
`define PELW_IDX_FLAG 16'hF427
`define PELW_IDX_CODE 16'hF428
`define PELW_IDX_EXEC_COUNT 16'hF432
`define PELW_IDX_WD_RELOAD 16'hF443
`define PELW_IDX_INT_STATUS 16'hF42A
`define PELW_IDX_INT_ENABLE 16'hF42B

// Reset values
`define PELW_RST_PARITY_MASK 12'h003
`define PELW_RST_MASK_BIT 1'b0
`define PELW_RST_EXEC_COUNT 16'h0000
`define PELW_RST_WD_RELOAD 13'h0000
`define PELW_RST_INT 2'h0

// Field positions in the first-error code
`define PELW_CODE_SOFT 15
`define PELW_CODE_LOOP 14
`define PELW_CODE_STACK 13
`define PELW_CODE_WD 12
`define PELW_PARITY_BITS 12

// Interrupt status bit positions
`define PELW_INT_NEW_ERROR 0
`define PELW_INT_WD_EXPIRY 1

// Watchdog step per clock
`define PELW_WD_STEP 1

`endif

//--- pelw_pkg.sv
package pelw_pkg;

  typedef logic [15:0] pelw_word_t;
  typedef logic [15:0] pelw_code_t;
  typedef logic [1:0] pelw_intr_t;

endpackage : pelw_pkg

//--- pelw_top.sv
// Summary of operation
// - Loop overrun reported when loop mask bit 0 is 0; mask resets to 0.
// - Each fault source has its own mask; only unmasked ones count.
// - Master flag bit 0 sets when any unmasked source faults; resets 0.
// - Master flag stays set until software pulses the clear bit.
// - Error code keeps only the first error until cleared.
// - Code bits 15..12: software, loop, stack, watchdog; 1 means error.
// - Code bits 11..0: data mem 1 banks, data mem 0 banks, prog mems, SRCs.
// - Software error stores execute-stage count in RW register, reset 0.
// - Watchdog loads the reload value and counts down by one per clock.
// - Watchdog reloads at every frame start.
// - Watchdog at zero raises a watchdog fault once a frame start has armed it, subject to its mask.
// - Reload value is 13 bits [12:0], reset 0, upper bits reserved.
// - Rising edge of clear bit clears the error logic; write 1 then 0.
// - Parity faults reported when mask bit is 0; SRC masks reset to 1.
`timescale 1ns/10ps
`include "pelw_cfg.svh"
module pelw_top
  import pelw_pkg::*;
#(
  parameter int ADDR_W = 18,
  parameter int PC_W = 16,
  parameter int WD_W = 13
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [`PELW_PARITY_BITS-1:0] parity_fault,
  input wire logic software_panic,
  input wire logic loop_overrun,
  input wire logic stack_overrun,
  input wire logic [PC_W-1:0] execute_pc,
  input wire logic frame_start,
  output logic panic_flag,
  output logic irq
);

  // Bus side
  logic [15:0] reg_idx;
  logic setup;
  logic access;
  logic wr_en;
  logic rd_en;
  logic hit;
  pelw_word_t rd_word;
  logic [31:0] prdata_q;
  logic slverr_q;

  logic wr_clear;
  logic wr_parity_mask;
  logic wr_soft_mask;
  logic wr_wd_mask;
  logic wr_stack_mask;
  logic wr_loop_mask;
  logic wr_exec_count;
  logic wr_wd_reload;
  logic wr_int_enable;
  logic rd_int_status;

  // Software-visible registers
  logic clear_bit_q;
  logic clear_pulse_q;
  logic [`PELW_PARITY_BITS-1:0] parity_mask_q;
  logic soft_mask_q;
  logic wd_mask_q;
  logic stack_mask_q;
  logic loop_mask_q;
  logic [PC_W-1:0] exec_count_q;
  logic [WD_W-1:0] wd_reload_q;
  pelw_intr_t int_status_q;
  pelw_intr_t int_enable_q;

  // Fault path
  pelw_code_t raw_fault;
  pelw_code_t fault_mask;
  pelw_code_t code;
  logic flag;
  logic new_error;
  logic wd_pulse;
  pelw_intr_t int_events;

  // Only the documented widths are served
  if (ADDR_W != 18)
  begin : g_bad_addr_w
    $error("pelw_top: ADDR_W must be 18");
  end
  if (PC_W != 16)
  begin : g_bad_pc_w
    $error("pelw_top: PC_W must be 16");
  end
  if (WD_W != 13)
  begin : g_bad_wd_w
    $error("pelw_top: WD_W must be 13");
  end

  // Bus decode; zero wait states, read data latched in the setup cycle
  assign reg_idx = paddr[17:2];
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr_en = access & pwrite & hit;
  assign rd_en = access & ~pwrite & hit;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = access & slverr_q;

  // One strobe per register access
  assign wr_clear = wr_en && (reg_idx == `PELW_IDX_CLEAR);
  assign wr_parity_mask = wr_en && (reg_idx == `PELW_IDX_PARITY_MASK);
  assign wr_soft_mask = wr_en && (reg_idx == `PELW_IDX_SOFT_MASK);
  assign wr_wd_mask = wr_en && (reg_idx == `PELW_IDX_WD_MASK);
  assign wr_stack_mask = wr_en && (reg_idx == `PELW_IDX_STACK_MASK);
  assign wr_loop_mask = wr_en && (reg_idx == `PELW_IDX_LOOP_MASK);
  assign wr_exec_count = wr_en && (reg_idx == `PELW_IDX_EXEC_COUNT);
  assign wr_wd_reload = wr_en && (reg_idx == `PELW_IDX_WD_RELOAD);
  assign wr_int_enable = wr_en && (reg_idx == `PELW_IDX_INT_ENABLE);
  assign rd_int_status = rd_en && (reg_idx == `PELW_IDX_INT_STATUS);

  // Read mux; reserved bits read 0
  always_comb
  begin
    rd_word = '0;
    hit = 1'b1;
    unique case (reg_idx)
      `PELW_IDX_CLEAR:
        rd_word[0] = clear_bit_q;
      `PELW_IDX_PARITY_MASK:
        rd_word[`PELW_PARITY_BITS-1:0] = parity_mask_q;
      `PELW_IDX_SOFT_MASK:
        rd_word[0] = soft_mask_q;
      `PELW_IDX_WD_MASK:
        rd_word[0] = wd_mask_q;
      `PELW_IDX_STACK_MASK:
        rd_word[0] = stack_mask_q;
      `PELW_IDX_LOOP_MASK:
        rd_word[0] = loop_mask_q;
      `PELW_IDX_FLAG:
        rd_word[0] = flag;
      `PELW_IDX_CODE:
        rd_word = code;
      `PELW_IDX_EXEC_COUNT:
        rd_word = exec_count_q;
      `PELW_IDX_WD_RELOAD:
        rd_word[WD_W-1:0] = wd_reload_q;
      `PELW_IDX_INT_STATUS:
        rd_word[1:0] = int_status_q;
      `PELW_IDX_INT_ENABLE:
        rd_word[1:0] = int_enable_q;
      default:
        hit = 1'b0;
    endcase
  end

  // Read word frozen at setup so the access cycle sees one coherent value
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0;
    else if (setup)
      prdata_q <= pwrite ? 32'h0 : {16'h0000, rd_word};
  end

  // Decode error latched alongside the read word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      slverr_q <= 1'b0;
    else if (setup)
      slverr_q <= ~hit;
  end

  // Clear fires once on the 0 to 1 write of the clear bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clear_bit_q <= 1'b0;
    else if (wr_clear)
      clear_bit_q <= pwdata[0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clear_pulse_q <= 1'b0;
    else
      clear_pulse_q <= wr_clear && pwdata[0] && !clear_bit_q;
  end

  // Mask registers: 1 suppresses the source
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      parity_mask_q <= `PELW_RST_PARITY_MASK;
    else if (wr_parity_mask)
      parity_mask_q <= pwdata[`PELW_PARITY_BITS-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      soft_mask_q <= `PELW_RST_MASK_BIT;
    else if (wr_soft_mask)
      soft_mask_q <= pwdata[0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wd_mask_q <= `PELW_RST_MASK_BIT;
    else if (wr_wd_mask)
      wd_mask_q <= pwdata[0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stack_mask_q <= `PELW_RST_MASK_BIT;
    else if (wr_stack_mask)
      stack_mask_q <= pwdata[0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      loop_mask_q <= `PELW_RST_MASK_BIT;
    else if (wr_loop_mask)
      loop_mask_q <= pwdata[0];
  end

  // Hardware capture on a software error wins over a bus write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      exec_count_q <= `PELW_RST_EXEC_COUNT;
    else if (software_panic)
      exec_count_q <= execute_pc;
    else if (wr_exec_count)
      exec_count_q <= pwdata[PC_W-1:0];
  end

  // Reserved bits above the field are dropped on write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wd_reload_q <= `PELW_RST_WD_RELOAD;
    else if (wr_wd_reload)
      wd_reload_q <= pwdata[WD_W-1:0];
  end

  // Fault vector laid out exactly as the code register reads
  always_comb
  begin
    raw_fault = '0;
    raw_fault[`PELW_CODE_SOFT] = software_panic;
    raw_fault[`PELW_CODE_LOOP] = loop_overrun;
    raw_fault[`PELW_CODE_STACK] = stack_overrun;
    raw_fault[`PELW_CODE_WD] = wd_pulse;
    raw_fault[`PELW_PARITY_BITS-1:0] = parity_fault;
  end

  // Masks share the code layout so one AND gates every source
  always_comb
  begin
    fault_mask = '0;
    fault_mask[`PELW_CODE_SOFT] = soft_mask_q;
    fault_mask[`PELW_CODE_LOOP] = loop_mask_q;
    fault_mask[`PELW_CODE_STACK] = stack_mask_q;
    fault_mask[`PELW_CODE_WD] = wd_mask_q;
    fault_mask[`PELW_PARITY_BITS-1:0] = parity_mask_q;
  end

  // Clear restarts the watchdog from the reload value
  pelw_watchdog #(
    .WD_W(WD_W)
  ) u_watchdog (
    .pclk(pclk),
    .presetn(presetn),
    .reload_value(wd_reload_q),
    .frame_start(frame_start),
    .clear(clear_pulse_q),
    .count(),
    .expired(),
    .expire_pulse(wd_pulse)
  );

  // Flag and first code share one clear pulse
  pelw_capture u_capture (
    .pclk(pclk),
    .presetn(presetn),
    .raw_fault(raw_fault),
    .fault_mask(fault_mask),
    .clear(clear_pulse_q),
    .flag(flag),
    .code(code),
    .new_error(new_error)
  );

  // Flag pin driven straight from its flop
  assign panic_flag = flag;

  // Status events: a new first error and each watchdog expiry
  always_comb
  begin
    int_events = '0;
    int_events[`PELW_INT_NEW_ERROR] = new_error;
    int_events[`PELW_INT_WD_EXPIRY] = wd_pulse;
  end

  // Read clears only the bits that were returned
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_status_q <= `PELW_RST_INT;
    else if (rd_int_status)
      int_status_q <= (int_status_q & ~prdata_q[1:0]) | int_events;
    else
      int_status_q <= int_status_q | int_events;
  end

  // 1 enables a source, unlike the fault masks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_enable_q <= `PELW_RST_INT;
    else if (wr_int_enable)
      int_enable_q <= pwdata[1:0];
  end

  // Level output; falls once the status read clears the bit
  assign irq = |(int_status_q & int_enable_q);

endmodule : pelw_top

//--- pelw_watchdog.sv
`timescale 1ns/10ps
`include "pelw_cfg.svh"
module pelw_watchdog
  import pelw_pkg::*;
#(
  parameter int WD_W = 13
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WD_W-1:0] reload_value,
  input wire logic frame_start,
  input wire logic clear,
  output logic [WD_W-1:0] count,
  output logic expired,
  output logic expire_pulse
);

  logic [WD_W-1:0] count_q;
  logic armed_q;
  logic expired_q;
  logic reload;

  if (WD_W < 1 || WD_W > 16)
  begin : g_bad_wd_w
    $error("pelw_watchdog: WD_W must be 1 to 16");
  end

  assign reload = frame_start | clear;
  // One event per expiry: only while not yet marked expired
  assign expire_pulse = armed_q & ~reload & (count_q == '0) & ~expired_q;
  assign count = count_q;
  assign expired = expired_q;

  // Armed by the first frame start so reset alone never expires
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      armed_q <= 1'b0;
    else if (frame_start)
      armed_q <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_q <= '0;
    else if (reload)
      count_q <= reload_value;
    else if (count_q != '0)
      count_q <= count_q - WD_W'(`PELW_WD_STEP);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      expired_q <= 1'b0;
    else if (reload)
      expired_q <= 1'b0;
    else if (expire_pulse)
      expired_q <= 1'b1;
  end

endmodule : pelw_watchdog

//--- tb_top.sv
`timescale 1ns/10ps
`include "pelw_cfg.svh"
module tb_top
  import pelw_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, frame_start;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, panic_flag, irq;
  pelw_code_t flt;
  logic [15:0] execute_pc;
  int errors = 0;
  int check_count = 0;

  pelw_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .parity_fault(flt[11:0]), .software_panic(flt[15]),
    .loop_overrun(flt[14]), .stack_overrun(flt[13]),
    .execute_pc(execute_pc), .frame_start(frame_start),
    .panic_flag(panic_flag), .irq(irq));

  initial
  begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end

  task automatic conclude;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [15:0] ix,
    input logic [31:0] d, output logic [31:0] r, output logic er);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {ix, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1)
    begin
      errors++;
      conclude();
    end
    else
    begin
      r = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      // Idle cycle: back-to-back calls never drive psel twice at once
      @(posedge pclk);
    end
  endtask : apb

  task automatic wr(input logic [15:0] ix, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'h1, ix, d, r, e);
  endtask : wr

  task automatic rd(input logic [15:0] ix, input logic [31:0] x,
    input string nm);
    logic [31:0] r;
    logic e;
    apb(1'h0, ix, 32'h0, r, e);
    chk(nm, x, r);
  endtask : rd

  task automatic pulse(input pelw_code_t v);
    flt <= v;
    @(posedge pclk);
    flt <= 16'h0;
    @(posedge pclk);
  endtask : pulse

  task automatic clr;
    wr(`PELW_IDX_CLEAR, 32'h1);
    wr(`PELW_IDX_CLEAR, 32'h0);
  endtask : clr

  task automatic s_reset;
    logic [31:0] r;
    logic e;
    rd(`PELW_IDX_PARITY_MASK, 32'h3, "par_mask");
    rd(`PELW_IDX_LOOP_MASK, 32'h0, "loop_mask");
    rd(`PELW_IDX_FLAG, 32'h0, "flag");
    rd(`PELW_IDX_CODE, 32'h0, "code");
    rd(`PELW_IDX_EXEC_COUNT, 32'h0, "exec");
    rd(`PELW_IDX_WD_RELOAD, 32'h0, "reload");
    apb(1'h0, 16'hF429, 32'h0, r, e);
    chk("slverr", 32'h1, {31'h0, e});
    chk("unmapped", 32'h0, r);
  endtask : s_reset

  task automatic s_mask;
    pulse(16'h0003);
    wr(`PELW_IDX_LOOP_MASK, 32'h1);
    wr(`PELW_IDX_SOFT_MASK, 32'h1);
    wr(`PELW_IDX_STACK_MASK, 32'h1);
    wr(`PELW_IDX_PARITY_MASK, 32'hFFF);
    pulse(16'hEFFF);
    rd(`PELW_IDX_FLAG, 32'h0, "flag_masked");
    rd(`PELW_IDX_CODE, 32'h0, "code_masked");
    wr(`PELW_IDX_LOOP_MASK, 32'h0);
    wr(`PELW_IDX_SOFT_MASK, 32'h0);
    wr(`PELW_IDX_STACK_MASK, 32'h0);
    wr(`PELW_IDX_PARITY_MASK, 32'h0);
  endtask : s_mask

  task automatic s_codes;
    for (int i = 0; i < 16; i++)
      if (i != 12)
      begin
        pulse(pelw_code_t'(1) << i);
        rd(`PELW_IDX_CODE, 32'h1 << i, "code_bit");
        rd(`PELW_IDX_FLAG, 32'h1, "flag_set");
        clr();
        rd(`PELW_IDX_CODE, 32'h0, "code_clr");
      end
  endtask : s_codes

  task automatic s_first;
    pulse(16'h2000);
    pulse(16'h4000);
    rd(`PELW_IDX_CODE, 32'h2000, "first");
    rd(`PELW_IDX_FLAG, 32'h1, "sticky");
    chk("panic_flag", 32'h1, {31'h0, panic_flag});
    clr();
    rd(`PELW_IDX_FLAG, 32'h0, "cleared");
    pulse(16'h4000);
    rd(`PELW_IDX_CODE, 32'h4000, "rearm");
    execute_pc <= 16'h5A3C;
    pulse(16'h8000);
    rd(`PELW_IDX_EXEC_COUNT, 32'h5A3C, "exec_cap");
    wr(`PELW_IDX_EXEC_COUNT, 32'h1234);
    rd(`PELW_IDX_EXEC_COUNT, 32'h1234, "exec_rw");
    clr();
  endtask : s_first

  task automatic frame;
    frame_start <= 1'h1;
    @(posedge pclk);
    frame_start <= 1'h0;
  endtask : frame

  task automatic s_wd;
    wr(`PELW_IDX_WD_RELOAD, 32'hFFFF);
    rd(`PELW_IDX_WD_RELOAD, 32'h1FFF, "reload_w");
    wr(`PELW_IDX_WD_RELOAD, 32'h14);
    repeat (4)
    begin
      frame();
      repeat (15) @(posedge pclk);
    end
    rd(`PELW_IDX_FLAG, 32'h0, "wd_reloaded");
    frame();
    repeat (20) @(posedge pclk);
    rd(`PELW_IDX_FLAG, 32'h0, "wd_early");
    repeat (4) @(posedge pclk);
    rd(`PELW_IDX_CODE, 32'h1000, "wd_code");
    rd(`PELW_IDX_INT_STATUS, 32'h3, "wd_status");
    repeat (20) @(posedge pclk);
    rd(`PELW_IDX_INT_STATUS, 32'h0, "wd_once");
    wr(`PELW_IDX_WD_MASK, 32'h1);
    clr();
    repeat (30) @(posedge pclk);
    rd(`PELW_IDX_FLAG, 32'h0, "wd_masked");
    wr(`PELW_IDX_WD_RELOAD, 32'h1FFF);
    wr(`PELW_IDX_WD_MASK, 32'h0);
  endtask : s_wd

  task automatic s_irq;
    logic [31:0] r;
    logic e;
    apb(1'h0, `PELW_IDX_INT_STATUS, 32'h0, r, e);
    wr(`PELW_IDX_INT_ENABLE, 32'h0);
    pulse(16'h2000);
    chk("irq_off", 32'h0, {31'h0, irq});
    wr(`PELW_IDX_INT_ENABLE, 32'h3);
    @(posedge pclk);
    chk("irq_on", 32'h1, {31'h0, irq});
    rd(`PELW_IDX_INT_STATUS, 32'h1, "status");
    @(posedge pclk);
    chk("irq_clr", 32'h0, {31'h0, irq});
  endtask : s_irq

  initial
  begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 18'h0;
    pwdata = 32'h0;
    flt = 16'h0;
    execute_pc = 16'h0;
    frame_start = 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    s_reset();
    s_mask();
    s_codes();
    s_first();
    s_wd();
    s_irq();
    conclude();
  end
endmodule : tb_top

bind pelw_top pelw_chk #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .parity_fault(parity_fault),
  .software_panic(software_panic), .loop_overrun(loop_overrun),
  .stack_overrun(stack_overrun), .frame_start(frame_start),
  .panic_flag(panic_flag));
